// ---- aso_defs.vh ----
// Register map, field positions and sizes for the sample sequencer
`ifndef ASO_DEFS_VH
`define ASO_DEFS_VH
`define ASO_A_CFG      8'h00
`define ASO_A_CMD      8'h04
`define ASO_A_DIV      8'h08
`define ASO_A_AI_EN    8'h0C
`define ASO_A_AI_SEL   8'h10
`define ASO_A_AI_DATA  8'h14
`define ASO_A_AO_DATA0 8'h18
`define ASO_A_AO_DATA1 8'h1C
`define ASO_A_STATUS   8'h20
`define ASO_A_MASK     8'h24
`define ASO_A_STATE    8'h28
`define ASO_CFG_AI_EXT   0
`define ASO_CFG_AO_EXT   1
`define ASO_CFG_AI_TRIG  2
`define ASO_CFG_AO_TRIG  3
`define ASO_CFG_TRIG_FALL 4
`define ASO_CFG_AO_SYNC  5
`define ASO_CMD_AI_START 0
`define ASO_CMD_AI_STOP  1
`define ASO_CMD_AO_START 2
`define ASO_CMD_AO_STOP  3
`define ASO_CMD_AO_SYNC  4
`define ASO_ST_OVF 0
`define ASO_ST_UNR 1
`define ASO_AO_CH_BIT 16
`define ASO_FIFO_AW    9
`define ASO_FIFO_DEPTH 10'd512
`define ASO_FIFO_STOP  10'd510
`define ASO_DIV_RST    16'h00F9
`endif

// ---- aso_fifo.v ----
// Sample FIFO with registered read data
`timescale 1ns/1ns
`default_nettype none
`include "aso_defs.vh"
module aso_fifo
(
    input  wire                   sys_clk,
    input  wire                   rst,
    input  wire                   push,
    input  wire [31:0]            wdata,
    input  wire                   pop,
    output reg  [31:0]            rdata_r,
    output reg  [`ASO_FIFO_AW:0]  count_r,
    output wire                   full,
    output wire                   empty
);
    reg [31:0]                mem [0:(1<<`ASO_FIFO_AW)-1];
    reg [`ASO_FIFO_AW-1:0]    wptr_r;
    reg [`ASO_FIFO_AW-1:0]    rptr_r;
    wire                      do_push;
    wire                      do_pop;

    assign full    = (count_r == `ASO_FIFO_DEPTH);
    assign empty   = (count_r == 10'h000);
    assign do_push = push & ~full;
    assign do_pop  = pop & ~empty;

    always @(posedge sys_clk)
    begin
        if (do_push)
            mem[wptr_r] <= wdata;
    end

    always @(posedge sys_clk)
    begin
        if (rst)
        begin
            wptr_r  <= {`ASO_FIFO_AW{1'b0}};
            rptr_r  <= {`ASO_FIFO_AW{1'b0}};
            count_r <= 10'h000;
            rdata_r <= 32'h00000000;
        end
        else
        begin
            if (do_push)
                wptr_r <= wptr_r + 1'b1;
            if (do_pop)
            begin
                rptr_r  <= rptr_r + 1'b1;
                rdata_r <= mem[rptr_r];
            end
            if (do_push & ~do_pop)
                count_r <= count_r + 1'b1;
            else if (do_pop & ~do_push)
                count_r <= count_r - 1'b1;
        end
    end
endmodule
`default_nettype wire

// ---- aso_seq.v ----
// Analog input/output sample sequencer with AHB-Lite registers
// Notes on behaviour
// - One-shot read returns selected channel's present converted value directly.
// - Buffered input starts all enabled channels together on each sample edge.
// - Sample clock source is internal divider or external pin, per path.
// - Buffered input samples queue in a FIFO, drained by a DMA stream.
// - Static output: each register write stores the value for the addressed DAC.
// - Asynchronous static mode loads a channel's DAC as soon as written.
// - Synchronous mode holds written values until the sync command loads all.
// - Buffered output samples arrive by DMA into a FIFO, one per DAC load.
// - Buffered output samples are applied only at sample clock edges.
// - Buffered paths can wait for a hardware trigger before running.
// - Trigger active edge is selectable rising or falling.
`timescale 1ns/1ns
`default_nettype none
`include "aso_defs.vh"
module aso_seq
(
    input  wire         sys_clk,
    input  wire         rst,
    input  wire         hsel,
    input  wire [31:0]  haddr,
    input  wire [1:0]   htrans,
    input  wire         hwrite,
    input  wire [2:0]   hsize,
    input  wire [31:0]  hwdata,
    input  wire         hready,
    output reg  [31:0]  hrdata_r,
    output reg          hreadyout_r,
    output reg          hresp_r,
    output reg          irq_r,
    input  wire         ai_ext_clk,
    input  wire         ao_ext_clk,
    input  wire         trig_in,
    output reg  [7:0]   adc_start_r,
    input  wire         adc_done,
    input  wire [127:0] adc_data,
    output reg  [15:0]  dac0_code_r,
    output reg  [15:0]  dac1_code_r,
    output reg  [1:0]   dac_load_r,
    output reg          ai_dma_valid_r,
    output wire [31:0]  ai_dma_data,
    input  wire         ai_dma_ready,
    input  wire         ao_dma_valid,
    input  wire [31:0]  ao_dma_data,
    output reg          ao_dma_ready_r
);
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_WAIT = 3'b010;
    localparam [2:0] ST_RUN  = 3'b100;

    reg  [5:0]   cfg_r;
    reg  [15:0]  div_r;
    reg  [15:0]  div_cnt_r;
    reg  [7:0]   ai_en_r;
    reg  [2:0]   ai_sel_r;
    reg  [15:0]  ao_stage0_r;
    reg  [15:0]  ao_stage1_r;
    reg  [1:0]   status_r;
    reg  [1:0]   mask_r;
    reg          wr_pend_r;
    reg  [7:0]   wr_addr_r;
    reg  [2:0]   ai_st_r;
    reg  [2:0]   ao_st_r;
    reg  [2:0]   ai_st_nxt;
    reg  [2:0]   ao_st_nxt;
    reg          ai_ext_d_r;
    reg          ao_ext_d_r;
    reg          trig_d_r;
    reg  [127:0] snap_r;
    reg  [7:0]   pend_r;
    reg  [7:0]   conv_en_r;
    reg          conv_busy_r;
    reg          ao_pop_d_r;
    reg  [31:0]  rd_nxt;
    reg  [2:0]   pick;
    integer      i;

    wire         acc;
    wire         rd_acc;
    wire         wr_cmd;
    wire         int_tick;
    wire         trig_edge;
    wire         ai_smp;
    wire         ao_smp;
    wire         ai_push;
    wire         ai_pop;
    wire         ai_full;
    wire         ai_empty;
    wire         ao_pop;
    wire         ao_full;
    wire         ao_empty;
    wire [31:0]  ao_rd;
    wire [`ASO_FIFO_AW:0] ai_cnt;
    wire [`ASO_FIFO_AW:0] ao_cnt;
    wire [1:0]   st_set;
    wire [1:0]   st_clr;
    wire [31:0]  ai_word;

    assign acc    = hsel & htrans[1] & hready;
    assign rd_acc = acc & ~hwrite;
    assign wr_cmd = wr_pend_r & (wr_addr_r == `ASO_A_CMD);

    // Internal sample clock: one-cycle tick every div_r+1 cycles;
    // a smaller new divider must not wait for the count to wrap
    assign int_tick = (div_cnt_r >= div_r);

    assign trig_edge = cfg_r[`ASO_CFG_TRIG_FALL] ?
                       (~trig_in & trig_d_r) : (trig_in & ~trig_d_r);

    assign ai_smp = (ai_st_r == ST_RUN) &
                    (cfg_r[`ASO_CFG_AI_EXT] ?
                     (ai_ext_clk & ~ai_ext_d_r) : int_tick);
    assign ao_smp = (ao_st_r == ST_RUN) &
                    (cfg_r[`ASO_CFG_AO_EXT] ?
                     (ao_ext_clk & ~ao_ext_d_r) : int_tick);

    // Lowest pending converted channel goes into the FIFO first
    always @*
    begin
        pick = 3'h0;
        for (i = 7; i >= 0; i = i - 1)
            if (pend_r[i])
                pick = i[2:0];
    end

    assign ai_word = {13'h0000, pick, snap_r[{pick, 4'h0} +: 16]};
    assign ai_push = (|pend_r) & ~ai_full;
    assign ai_pop  = ~ai_empty & (~ai_dma_valid_r | ai_dma_ready);
    assign ao_pop  = ao_smp & ~ao_empty;

    assign st_set[`ASO_ST_OVF] = (ai_smp & ai_full) |
                                 ((|pend_r) & ai_full);
    assign st_set[`ASO_ST_UNR] = ao_smp & ao_empty;
    assign st_clr = (rd_acc & (haddr[7:0] == `ASO_A_STATUS)) ?
                    2'b11 : 2'b00;

    aso_fifo u_ai_fifo
    (
        .sys_clk (sys_clk),
        .rst     (rst),
        .push    (ai_push),
        .wdata   (ai_word),
        .pop     (ai_pop),
        .rdata_r (ai_dma_data),
        .count_r (ai_cnt),
        .full    (ai_full),
        .empty   (ai_empty)
    );

    aso_fifo u_ao_fifo
    (
        .sys_clk (sys_clk),
        .rst     (rst),
        .push    (ao_dma_valid & ao_dma_ready_r),
        .wdata   (ao_dma_data),
        .pop     (ao_pop),
        .rdata_r (ao_rd),
        .count_r (ao_cnt),
        .full    (ao_full),
        .empty   (ao_empty)
    );

    always @*
    begin
        ai_st_nxt = ai_st_r;
        case (ai_st_r)
            ST_IDLE:
                if (wr_cmd & hwdata[`ASO_CMD_AI_START])
                    ai_st_nxt = cfg_r[`ASO_CFG_AI_TRIG] ? ST_WAIT : ST_RUN;
            ST_WAIT:
                if (wr_cmd & hwdata[`ASO_CMD_AI_STOP])
                    ai_st_nxt = ST_IDLE;
                else if (trig_edge)
                    ai_st_nxt = ST_RUN;
            ST_RUN:
                if (wr_cmd & hwdata[`ASO_CMD_AI_STOP])
                    ai_st_nxt = ST_IDLE;
            default:
                ai_st_nxt = ST_IDLE;
        endcase
    end

    always @*
    begin
        ao_st_nxt = ao_st_r;
        case (ao_st_r)
            ST_IDLE:
                if (wr_cmd & hwdata[`ASO_CMD_AO_START])
                    ao_st_nxt = cfg_r[`ASO_CFG_AO_TRIG] ? ST_WAIT : ST_RUN;
            ST_WAIT:
                if (wr_cmd & hwdata[`ASO_CMD_AO_STOP])
                    ao_st_nxt = ST_IDLE;
                else if (trig_edge)
                    ao_st_nxt = ST_RUN;
            ST_RUN:
                if (wr_cmd & hwdata[`ASO_CMD_AO_STOP])
                    ao_st_nxt = ST_IDLE;
            default:
                ao_st_nxt = ST_IDLE;
        endcase
    end

    // Read data prepared in the address phase, shown in the data phase
    always @*
    begin
        rd_nxt = 32'h00000000;
        case (haddr[7:0])
            `ASO_A_CFG:     rd_nxt = {26'h0000000, cfg_r};
            `ASO_A_DIV:     rd_nxt = {16'h0000, div_r};
            `ASO_A_AI_EN:   rd_nxt = {24'h000000, ai_en_r};
            `ASO_A_AI_SEL:  rd_nxt = {29'h00000000, ai_sel_r};
            `ASO_A_AI_DATA: rd_nxt = {16'h0000,
                                      adc_data[{ai_sel_r, 4'h0} +: 16]};
            `ASO_A_AO_DATA0: rd_nxt = {16'h0000, ao_stage0_r};
            `ASO_A_AO_DATA1: rd_nxt = {16'h0000, ao_stage1_r};
            `ASO_A_STATUS:  rd_nxt = {30'h00000000, status_r};
            `ASO_A_MASK:    rd_nxt = {30'h00000000, mask_r};
            `ASO_A_STATE:   rd_nxt = {6'h00, ao_cnt, ai_cnt, ao_st_r, ai_st_r};
            default:        rd_nxt = 32'h00000000;
        endcase
    end

    always @(posedge sys_clk)
    begin
        if (rst)
        begin
            hrdata_r    <= 32'h00000000;
            hreadyout_r <= 1'b1;
            hresp_r     <= 1'b0;
            wr_pend_r   <= 1'b0;
            wr_addr_r   <= 8'h00;
            cfg_r       <= 6'h00;
            div_r       <= `ASO_DIV_RST;
            ai_en_r     <= 8'h00;
            ai_sel_r    <= 3'h0;
            ao_stage0_r <= 16'h0000;
            ao_stage1_r <= 16'h0000;
            status_r    <= 2'h0;
            mask_r      <= 2'h0;
            irq_r       <= 1'b0;
        end
        else
        begin
            hreadyout_r <= 1'b1;
            hresp_r     <= 1'b0;
            wr_pend_r   <= acc & hwrite;
            if (acc)
                wr_addr_r <= haddr[7:0];
            if (rd_acc)
                hrdata_r <= rd_nxt;
            if (wr_pend_r)
            begin
                case (wr_addr_r)
                    `ASO_A_CFG:      cfg_r       <= hwdata[5:0];
                    `ASO_A_DIV:      div_r       <= hwdata[15:0];
                    `ASO_A_AI_EN:    ai_en_r     <= hwdata[7:0];
                    `ASO_A_AI_SEL:   ai_sel_r    <= hwdata[2:0];
                    `ASO_A_AO_DATA0: ao_stage0_r <= hwdata[15:0];
                    `ASO_A_AO_DATA1: ao_stage1_r <= hwdata[15:0];
                    `ASO_A_MASK:     mask_r      <= hwdata[1:0];
                    default:         mask_r      <= mask_r;
                endcase
            end
            // New events win over the read-clear
            status_r <= (status_r & ~st_clr) | st_set;
            irq_r    <= |(status_r & mask_r);
        end
    end

    always @(posedge sys_clk)
    begin
        if (rst)
        begin
            div_cnt_r  <= 16'h0000;
            ai_st_r    <= ST_IDLE;
            ao_st_r    <= ST_IDLE;
            ai_ext_d_r <= 1'b0;
            ao_ext_d_r <= 1'b0;
            trig_d_r   <= 1'b0;
        end
        else
        begin
            div_cnt_r  <= int_tick ? 16'h0000 : div_cnt_r + 16'h0001;
            ai_st_r    <= ai_st_nxt;
            ao_st_r    <= ao_st_nxt;
            ai_ext_d_r <= ai_ext_clk;
            ao_ext_d_r <= ao_ext_clk;
            trig_d_r   <= trig_in;
        end
    end

    // Buffered input: simultaneous starts, then serialise into the FIFO
    always @(posedge sys_clk)
    begin
        if (rst)
        begin
            adc_start_r    <= 8'h00;
            conv_en_r      <= 8'h00;
            conv_busy_r    <= 1'b0;
            snap_r         <= 128'h0;
            pend_r         <= 8'h00;
            ai_dma_valid_r <= 1'b0;
        end
        else
        begin
            adc_start_r <= ai_smp ? ai_en_r : 8'h00;
            if (ai_smp)
            begin
                conv_en_r   <= ai_en_r;
                conv_busy_r <= |ai_en_r;
            end
            else if (adc_done & conv_busy_r)
                conv_busy_r <= 1'b0;
            if (adc_done & conv_busy_r & ~ai_smp)
            begin
                snap_r <= adc_data;
                pend_r <= conv_en_r;
            end
            else if (|pend_r)
                pend_r[pick] <= 1'b0;
            ai_dma_valid_r <= ai_pop | (ai_dma_valid_r & ~ai_dma_ready);
        end
    end

    // DAC codes: static async, synchronous command, or buffered samples
    always @(posedge sys_clk)
    begin
        if (rst)
        begin
            dac0_code_r    <= 16'h0000;
            dac1_code_r    <= 16'h0000;
            dac_load_r     <= 2'b00;
            ao_pop_d_r     <= 1'b0;
            ao_dma_ready_r <= 1'b0;
        end
        else
        begin
            dac_load_r     <= 2'b00;
            ao_pop_d_r     <= ao_pop;
            ao_dma_ready_r <= (ao_cnt < `ASO_FIFO_STOP);
            if (wr_pend_r & ~cfg_r[`ASO_CFG_AO_SYNC])
            begin
                if (wr_addr_r == `ASO_A_AO_DATA0)
                begin
                    dac0_code_r   <= hwdata[15:0];
                    dac_load_r[0] <= 1'b1;
                end
                if (wr_addr_r == `ASO_A_AO_DATA1)
                begin
                    dac1_code_r   <= hwdata[15:0];
                    dac_load_r[1] <= 1'b1;
                end
            end
            if (wr_cmd & hwdata[`ASO_CMD_AO_SYNC])
            begin
                dac0_code_r <= ao_stage0_r;
                dac1_code_r <= ao_stage1_r;
                dac_load_r  <= 2'b11;
            end
            if (ao_pop_d_r)
            begin
                if (ao_rd[`ASO_AO_CH_BIT])
                begin
                    dac1_code_r   <= ao_rd[15:0];
                    dac_load_r[1] <= 1'b1;
                end
                else
                begin
                    dac0_code_r   <= ao_rd[15:0];
                    dac_load_r[0] <= 1'b1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ---- aso_chk.sv ----
// Port assertions for the sample sequencer
`timescale 1ns/1ns
`default_nettype none
module aso_chk
(
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic        hreadyout_r,
    input wire logic        hresp_r,
    input wire logic        irq_r,
    input wire logic [7:0]  adc_start_r,
    input wire logic [15:0] dac0_code_r,
    input wire logic [15:0] dac1_code_r,
    input wire logic [1:0]  dac_load_r,
    input wire logic        ai_dma_valid_r,
    input wire logic [31:0] ai_dma_data,
    input wire logic        ai_dma_ready,
    input wire logic        ao_dma_ready_r
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    a_bus_no_wait: assert property (hreadyout_r)
        else $error("bus wait state");
    a_resp_okay: assert property (!hresp_r)
        else $error("error response");
    a_start_one_cycle: assert property
        (|adc_start_r |=> adc_start_r == 8'h00)
        else $error("start pulse too long");
    a_load_one_cycle: assert property
        (|dac_load_r |=> dac_load_r == 2'h0)
        else $error("load pulse too long");
    a_dma_word_held: assert property
        (ai_dma_valid_r && !ai_dma_ready |=>
         ai_dma_valid_r && $stable(ai_dma_data))
        else $error("stream word dropped");
    a_dac0_with_load: assert property
        (!$stable(dac0_code_r) |-> dac_load_r[0])
        else $error("dac0 moved without load");
    a_dac1_with_load: assert property
        (!$stable(dac1_code_r) |-> dac_load_r[1])
        else $error("dac1 moved without load");
    a_ao_ready_up: assert property ($fell(rst) |=> ao_dma_ready_r)
        else $error("output stream not ready");
    a_irq_quiet: assert property ($fell(rst) |-> !irq_r)
        else $error("interrupt after reset");
    c_start: cover property (|adc_start_r);
    c_sync: cover property (dac_load_r == 2'h3);
    c_dma: cover property (ai_dma_valid_r && ai_dma_ready);
    c_irq: cover property ($rose(irq_r));
endmodule
bind aso_seq aso_chk chk_u (.sys_clk, .rst, .hreadyout_r, .hresp_r,
    .irq_r, .adc_start_r, .dac0_code_r, .dac1_code_r, .dac_load_r,
    .ai_dma_valid_r, .ai_dma_data, .ai_dma_ready, .ao_dma_ready_r);
`default_nettype wire

// ---- aso_far.sv ----
// Converter and host stream model facing the sequencer
`timescale 1ns/1ns
`default_nettype none
module aso_far
(
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic [7:0]  adc_start_r,
    input  wire logic        ao_dma_ready_r,
    input  wire logic [3:0]  ao_n,
    output var  logic        adc_done,
    output var  logic        ai_dma_ready,
    output var  logic        ao_dma_valid,
    output var  logic [31:0] ao_dma_data
);
    logic [2:0]  conv_r;
    logic [3:0]  idx_r;
    logic [1:0]  ph_r;
    logic [31:0] w;
    assign w = {15'h0, idx_r[0], 12'h5A0, idx_r};
    // Results three cycles after start
    assign adc_done = conv_r[2];
    // Host stalls half the time
    assign ai_dma_ready = ph_r[1];
    assign ao_dma_valid = idx_r < ao_n;
    // Idle word is inverted
    assign ao_dma_data = ao_dma_valid ? w : ~w;
    always @(posedge sys_clk)
        if (rst)
        begin
            conv_r <= 3'h0;
            idx_r <= 4'h0;
            ph_r <= 2'h0;
        end
        else
        begin
            conv_r <= {conv_r[1:0], |adc_start_r};
            ph_r <= ph_r + 2'h1;
            if (ao_dma_valid && ao_dma_ready_r)
                idx_r <= idx_r + 4'h1;
        end
endmodule
`default_nettype wire

// ---- test_analog_io_sample_sequencer.sv ----
// Self-checking bench for the sample sequencer
`timescale 1ns/1ns
`default_nettype none
`include "aso_defs.vh"
module test_analog_io_sample_sequencer;
    logic         sys_clk = 1'b0;
    logic         rst = 1'b1;
    logic         hsel = 1'b0;
    logic [31:0]  haddr = 32'h0;
    logic [1:0]   htrans = 2'h0;
    logic         hwrite = 1'b0;
    logic [2:0]   hsize = 3'h2;
    logic [31:0]  hwdata = 32'h0;
    logic         ai_ext_clk = 1'b0;
    logic         ao_ext_clk = 1'b0;
    logic         trig_in = 1'b0;
    logic [127:0] adc_data = 128'h0;
    logic [3:0]   ao_n = 4'h0;
    logic         rd_dp = 1'b0;
    wire  [31:0]  hrdata_r, ai_dma_data, ao_dma_data;
    wire  [15:0]  dac0_code_r, dac1_code_r;
    wire  [7:0]   adc_start_r;
    wire  [1:0]   dac_load_r;
    wire          hreadyout_r, hresp_r, irq_r, adc_done, ai_dma_valid_r;
    wire          ai_dma_ready, ao_dma_valid, ao_dma_ready_r;
    logic [63:0]  rq[$], sq[$], aq[$], dq[$];
    logic [15:0]  d0 = 16'h0, d1 = 16'h0;
    logic [7:0]   en;
    logic [31:0]  seed = 32'h0A54F150;
    int           error_cnt = 0, samples_checked = 0, n, k;
    aso_seq dut_u
    (
        .sys_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout_r), .hrdata_r, .hreadyout_r, .hresp_r, .irq_r,
        .ai_ext_clk, .ao_ext_clk, .trig_in, .adc_start_r, .adc_done,
        .adc_data, .dac0_code_r, .dac1_code_r, .dac_load_r,
        .ai_dma_valid_r, .ai_dma_data, .ai_dma_ready, .ao_dma_valid,
        .ao_dma_data, .ao_dma_ready_r
    );
    aso_far far_u
    (
        .sys_clk, .rst, .adc_start_r, .ao_dma_ready_r, .ao_n, .adc_done,
        .ai_dma_ready, .ao_dma_valid, .ao_dma_data
    );
    always #2 sys_clk = ~sys_clk;
    task automatic chk(input logic [63:0] g, input logic [63:0] e);
        samples_checked++;
        if (g !== e)
        begin
            error_cnt++;
            $display("mismatch at %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic close_out;
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        @(posedge sys_clk);
        while (hreadyout_r !== 1'b1)
            @(posedge sys_clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        rd_dp <= ~w;
        @(posedge sys_clk);
        while (hreadyout_r !== 1'b1)
            @(posedge sys_clk);
        rd_dp <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        rq.push_back({32'h0, e});
        bus(1'b0, a, 32'h0);
    endtask
    task automatic tick(input logic ao);
        {ao_ext_clk, ai_ext_clk} <= ao ? 2'b10 : 2'b01;
        repeat (2) @(posedge sys_clk);
        {ao_ext_clk, ai_ext_clk} <= 2'b00;
        repeat (24) @(posedge sys_clk);
    endtask
    task automatic ai_exp;
        sq.push_back({56'h0, en});
        for (int c = 0; c < 8; c++)
            if (en[c])
                aq.push_back({45'h0, c[2:0], adc_data[16*c+:16]});
    endtask
    task automatic aset(input logic c, input logic ld);
        logic [15:0] v;
        v = 16'($random(seed));
        if (c)
            d1 = v;
        else
            d0 = v;
        if (ld)
            dq.push_back({30'h0, c, ~c, d1, d0});
        wr(c ? `ASO_A_AO_DATA1 : `ASO_A_AO_DATA0, {16'h0, v});
    endtask
    // Result monitor against the oldest note
    always @(posedge sys_clk)
        if (!rst)
        begin
            if (rd_dp && hreadyout_r)
                chk(hrdata_r, rq.size() ? rq.pop_front() : 64'hBAD);
            if (|adc_start_r)
                chk(adc_start_r, sq.size() ? sq.pop_front() : 64'hBAD);
            if (ai_dma_valid_r && ai_dma_ready)
                chk(ai_dma_data, aq.size() ? aq.pop_front() : 64'hBAD);
            if (|dac_load_r)
                chk({dac_load_r, dac1_code_r, dac0_code_r},
                    dq.size() ? dq.pop_front() : 64'hBAD);
        end
    initial
    begin
        #100000;
        error_cnt++;
        close_out;
    end
    initial
    begin
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        adc_data <= {$random(seed), $random(seed), $random(seed),
                     $random(seed)};
        en = 8'($random(seed)) | 8'h01;
        @(posedge sys_clk);
        rd(`ASO_A_DIV, 32'h00F9);
        rd(`ASO_A_STATE, 32'h09);
        rd(8'h3C, 32'h0);
        for (k = 0; k < 8; k++)
        begin
            wr(`ASO_A_AI_SEL, 32'(k));
            rd(`ASO_A_AI_DATA, {16'h0, adc_data[16*k+:16]});
        end
        aset(1'b0, 1'b1);
        aset(1'b1, 1'b1);
        wr(`ASO_A_CFG, 32'h20);
        aset(1'b0, 1'b0);
        aset(1'b1, 1'b0);
        rd(`ASO_A_AO_DATA1, {16'h0, d1});
        dq.push_back({30'h0, 2'h3, d1, d0});
        wr(`ASO_A_CMD, 32'h10);
        wr(`ASO_A_AI_EN, {24'h0, en});
        wr(`ASO_A_CFG, 32'h15);
        tick(1'b0);
        wr(`ASO_A_CMD, 32'h1);
        rd(`ASO_A_STATE, 32'h0A);
        tick(1'b0);
        trig_in <= 1'b1;
        repeat (3) @(posedge sys_clk);
        tick(1'b0);
        trig_in <= 1'b0;
        repeat (3) @(posedge sys_clk);
        for (k = 0; k < 2; k++)
        begin
            ai_exp;
            tick(1'b0);
        end
        wr(`ASO_A_CMD, 32'h2);
        tick(1'b0);
        wr(`ASO_A_DIV, 32'hF);
        wr(`ASO_A_CFG, 32'h0);
        ai_exp;
        ai_exp;
        wr(`ASO_A_CMD, 32'h1);
        n = 0;
        while (adc_start_r === 8'h00 && n < 100)
        begin
            @(posedge sys_clk);
            n++;
        end
        n = 0;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (adc_start_r === 8'h00 && n < 100);
        chk(64'(n), 64'd16);
        wr(`ASO_A_CMD, 32'h2);
        wr(`ASO_A_MASK, 32'h0);
        ao_n <= 4'h4;
        for (k = 0; k < 4; k++)
        begin
            if (k[0])
                d1 = {12'h5A0, 4'(k)};
            else
                d0 = {12'h5A0, 4'(k)};
            dq.push_back({30'h0, k[0], ~k[0], d1, d0});
        end
        wr(`ASO_A_CFG, 32'hA);
        wr(`ASO_A_CMD, 32'h4);
        tick(1'b1);
        chk(dq.size(), 4);
        trig_in <= 1'b1;
        repeat (3) @(posedge sys_clk);
        repeat (5) tick(1'b1);
        wr(`ASO_A_CMD, 32'h8);
        chk(irq_r, 1'b0);
        wr(`ASO_A_MASK, 32'h2);
        repeat (3) @(posedge sys_clk);
        chk(irq_r, 1'b1);
        rd(`ASO_A_STATUS, 32'h2);
        repeat (3) @(posedge sys_clk);
        chk(irq_r, 1'b0);
        repeat (300) @(posedge sys_clk);
        chk(rq.size() + sq.size() + aq.size() + dq.size(), 0);
        close_out;
    end
endmodule
`default_nettype wire
